// ---- hw/kbc_pkg.sv ----
// Shared constants and types for the keyboard-controller host mailbox block
package kbc_pkg;
  localparam int MCLK_MHZ = 25;
  localparam int CORE_CLK_MHZ = 12;
  localparam int ACC_W = 6;

  localparam logic [7:0] ADDR_DATA = 8'h60;
  localparam logic [7:0] ADDR_CMD = 8'h64;
  localparam logic [7:0] ADDR_FAST = 8'h92;
  localparam int ADDR_CMD_BIT = 2;
  localparam int CFG_FAST_EN_BIT = 2;

  localparam int STS_OBF = 0;
  localparam int STS_IBF = 1;
  localparam int STS_CD = 3;
  localparam logic [7:0] STS_USER_MASK = 8'hF4;
  localparam logic [7:0] STS_RESET = 8'h00;

  localparam logic [7:0] FGR_RESET = 8'h24;
  localparam logic [7:0] FGR_FIXED = 8'h24;
  localparam int FGR_GATE = 1;
  localparam int FGR_RST = 0;

  localparam int LINE_KB_CLK = 0;
  localparam int LINE_KB_DAT = 1;
  localparam int LINE_AUX_CLK = 2;
  localparam int LINE_AUX_DAT = 3;
  localparam int LINE_COUNT = 4;

  localparam int FAST_DELAY_NS = 500;
  localparam int FAST_PULSE_NS = 1000;
  localparam int FAST_DELAY_CYC = (FAST_DELAY_NS * MCLK_MHZ + 999) / 1000;
  localparam int FAST_PULSE_CYC = (FAST_PULSE_NS * MCLK_MHZ + 999) / 1000;
  localparam int CORE_RST_PERIODS = 24;
  localparam int CORE_RST_REF_MHZ = 16;
  localparam int CORE_RST_CYC =
    (CORE_RST_PERIODS * MCLK_MHZ + CORE_RST_REF_MHZ - 1) / CORE_RST_REF_MHZ;

  localparam int ROM_BYTES = 2048;
  localparam int RAM_BYTES = 256;
  localparam int ROM_AW = $clog2(ROM_BYTES);
  localparam int RAM_AW = $clog2(RAM_BYTES);

  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_SLEEP = 2'b01,
    PWR_STOP = 2'b11
  } pwr_state_t;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_WAIT = 2'b01,
    FR_PULSE = 2'b11,
    FR_DONE = 2'b10
  } fr_state_t;
endpackage

// ---- hw/kbc_links_if.sv ----
// Interfaces joining the mailbox top to its reset pulser and core memory
`timescale 1ns/1ps
interface fast_reset_if;
  logic arm;
  logic reset_n;
  modport ctrl(output arm, input reset_n);
  modport pulser(input arm, output reset_n);
endinterface

interface core_mem_if;
  logic [kbc_pkg::ROM_AW-1:0] fetch_addr;
  logic [7:0] fetch_data;
  logic load_en;
  logic [kbc_pkg::ROM_AW-1:0] load_addr;
  logic [7:0] load_data;
  logic ram_we;
  logic [kbc_pkg::RAM_AW-1:0] ram_addr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  modport core(output fetch_addr, load_en, load_addr, load_data, ram_we, ram_addr,
    ram_wdata, input fetch_data, ram_rdata);
  modport mem(input fetch_addr, load_en, load_addr, load_data, ram_we, ram_addr,
    ram_wdata, output fetch_data, ram_rdata);
endinterface

// ---- hw/fast_reset_pulser.sv ----
// Delayed, one-shot active-low fast CPU reset pulse
`timescale 1ns/1ps
module fast_reset_pulser #(
  parameter int DELAY_CYC = kbc_pkg::FAST_DELAY_CYC,
  parameter int PULSE_CYC = kbc_pkg::FAST_PULSE_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  fast_reset_if.pulser fr
);
  import kbc_pkg::*;

  initial begin
    if (DELAY_CYC < 1 || PULSE_CYC < 1 || DELAY_CYC > 255 || PULSE_CYC > 255) begin
      $error("fast_reset_pulser: counts must lie in 1..255");
    end
  end

  fr_state_t st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next;
  logic out_n_reg, out_n_next;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    out_n_next = 1'b1;
    case (st_reg)
      FR_IDLE: begin
        if (fr.arm) begin
          st_next = FR_WAIT;
          cnt_next = 8'(DELAY_CYC - 1);
        end
      end
      FR_WAIT: begin
        if (cnt_reg == 8'h00) begin
          st_next = FR_PULSE;
          cnt_next = 8'(PULSE_CYC - 1);
          out_n_next = 1'b0;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      FR_PULSE: begin
        out_n_next = 1'b0;
        if (cnt_reg == 8'h00) begin
          st_next = FR_DONE;
          out_n_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      FR_DONE: begin
        if (!fr.arm) begin
          st_next = FR_IDLE;
        end
      end
      default: st_next = FR_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= FR_IDLE;
      cnt_reg <= 8'h00;
      out_n_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      out_n_reg <= out_n_next;
    end
  end

  assign fr.reset_n = out_n_reg;
endmodule

// ---- hw/core_memory.sv ----
// Controller core program ROM and data RAM
`timescale 1ns/1ps
module core_memory #(
  parameter int ROM_DEPTH = kbc_pkg::ROM_BYTES,
  parameter int RAM_DEPTH = kbc_pkg::RAM_BYTES
) (
  input wire logic mclk,
  core_mem_if.mem mem
);
  import kbc_pkg::*;

  initial begin
    if (ROM_DEPTH != (1 << ROM_AW) || RAM_DEPTH != (1 << RAM_AW)) begin
      $error("core_memory: depths must match the address widths");
    end
  end

  logic [7:0] rom [ROM_DEPTH];
  logic [7:0] ram [RAM_DEPTH];
  logic [7:0] fetch_reg;
  logic [7:0] ram_rd_reg;

  // ROM image writes are accepted at any time, including after the core leaves reset
  always_ff @(posedge mclk) begin
    if (mem.load_en) begin
      rom[mem.load_addr] <= mem.load_data;
    end
    if (mem.ram_we) begin
      ram[mem.ram_addr] <= mem.ram_wdata;
    end
    fetch_reg <= rom[mem.fetch_addr];
    ram_rd_reg <= ram[mem.ram_addr];
  end

  assign mem.fetch_data = fetch_reg;
  assign mem.ram_rdata = ram_rd_reg;
endmodule

// ---- hw/kbc_host_mailbox.sv ----
// Keyboard controller host mailbox, power modes and fast gate/reset port
`timescale 1ns/1ps
module kbc_host_mailbox #(
  parameter int RST_CYC = kbc_pkg::CORE_RST_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  input wire logic [7:0] kbd_reset_gate_cfg,
  output logic kbd_host_interrupt,
  output logic aux_host_interrupt,
  output logic alt_gate_line,
  output logic fast_cpu_reset_n,
  input wire logic cpu_dbb_wr,
  input wire logic cpu_dbb_rd,
  input wire logic cpu_sts_wr,
  input wire logic cpu_sts_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic cpu_halt,
  input wire logic cpu_stop,
  input wire logic cpu_en_flags,
  input wire logic cpu_ibf_irq_en,
  input wire logic cpu_tmr_irq_en,
  input wire logic timer_ovf,
  input wire logic cpu_tmr_ack,
  output logic [1:0] cpu_irq_req,
  output logic cpu_input_full_irq_n,
  input wire logic kbd_irq_port_bit,
  input wire logic aux_irq_port_bit,
  output logic core_reset_n,
  output logic alu_clk_en,
  output logic periph_clk_en,
  output logic osc_drive_en,
  output logic wake_call,
  output logic wake_resume,
  input wire logic [kbc_pkg::LINE_COUNT-1:0] cpu_line_low,
  input wire logic [kbc_pkg::LINE_COUNT-1:0] ps2_line_in,
  output logic [kbc_pkg::LINE_COUNT-1:0] ps2_line_out,
  output logic [kbc_pkg::LINE_COUNT-1:0] ps2_line_oe,
  output logic [kbc_pkg::LINE_COUNT-1:0] ps2_line_sense,
  input wire logic [kbc_pkg::ROM_AW-1:0] cpu_fetch_addr,
  output logic [7:0] cpu_fetch_data,
  input wire logic rom_load_en,
  input wire logic [kbc_pkg::ROM_AW-1:0] rom_load_addr,
  input wire logic [7:0] rom_load_data,
  input wire logic cpu_ram_we,
  input wire logic [kbc_pkg::RAM_AW-1:0] cpu_ram_addr,
  input wire logic [7:0] cpu_ram_wdata,
  output logic [7:0] cpu_ram_rdata
);
  import kbc_pkg::*;

  initial begin
    if (RST_CYC < 1 || RST_CYC > 255) begin
      $error("kbc_host_mailbox: RST_CYC must lie in 1..255");
    end
  end

  fast_reset_if frif();
  core_mem_if memif();

  logic data_sel, cmd_sel, fast_sel, host_in_wr, obuf_rd;
  logic [7:0] status_byte;

  logic [7:0] ibuf_reg, ibuf_next;
  logic [7:0] obuf_reg, obuf_next;
  logic obf_reg, obf_next;
  logic ibf_reg, ibf_next;
  logic cd_reg, cd_next;
  logic [7:0] user_reg, user_next;
  logic [7:0] host_rdata_reg, host_rdata_next;
  logic [7:0] cpu_rdata_reg, cpu_rdata_next;
  logic [1:0] fgr_reg, fgr_next;
  logic en_flags_reg, en_flags_next;
  logic tmr_pend_reg, tmr_pend_next;
  logic kbd_host_interrupt_reg, kbd_host_interrupt_next;
  logic aux_host_interrupt_reg, aux_host_interrupt_next;
  logic [1:0] irq_req_reg, irq_req_next;
  logic ibf_irq_n_reg, ibf_irq_n_next;

  pwr_state_t pwr_reg, pwr_next;
  logic wake_call_reg, wake_call_next;
  logic wake_resume_reg, wake_resume_next;
  logic [ACC_W-1:0] acc_reg, acc_next;
  logic tick;
  logic [ACC_W-1:0] acc_sum;
  logic alu_en_reg, alu_en_next;
  logic per_en_reg, per_en_next;
  logic [7:0] rst_cnt_reg, rst_cnt_next;
  logic done_reg, done_next;
  logic [LINE_COUNT-1:0] line_low_reg, line_low_next;
  logic [LINE_COUNT-1:0] sense_reg;

  // Host port decode
  assign data_sel = (host_addr == ADDR_DATA);
  assign cmd_sel = (host_addr == ADDR_CMD);
  assign fast_sel = (host_addr == ADDR_FAST) && kbd_reset_gate_cfg[CFG_FAST_EN_BIT];
  assign host_in_wr = host_wr && (data_sel || cmd_sel);
  assign obuf_rd = host_rd && data_sel;

  always_comb begin
    status_byte = user_reg & STS_USER_MASK;
    status_byte[STS_OBF] = obf_reg;
    status_byte[STS_IBF] = ibf_reg;
    status_byte[STS_CD] = cd_reg;
  end

  // Mailbox buffers, flags and interrupt outputs
  always_comb begin
    ibuf_next = ibuf_reg;
    cd_next = cd_reg;
    obuf_next = obuf_reg;
    user_next = user_reg;
    fgr_next = fgr_reg;
    host_rdata_next = host_rdata_reg;
    cpu_rdata_next = cpu_rdata_reg;
    if (host_in_wr) begin
      ibuf_next = host_wdata;
      cd_next = host_addr[ADDR_CMD_BIT];
    end
    // Set beats clear when both land in one cycle
    ibf_next = (ibf_reg && !cpu_dbb_rd) || host_in_wr;
    obf_next = (obf_reg && !obuf_rd) || cpu_dbb_wr;
    if (cpu_dbb_wr) begin
      obuf_next = cpu_wdata;
    end
    if (cpu_sts_wr) begin
      user_next = cpu_wdata & STS_USER_MASK;
    end
    if (host_wr && fast_sel) begin
      fgr_next = host_wdata[1:0];
    end
    if (host_rd) begin
      if (data_sel) begin
        host_rdata_next = obuf_reg;
      end else if (cmd_sel) begin
        host_rdata_next = status_byte;
      end else if (fast_sel) begin
        host_rdata_next = FGR_FIXED | {6'b00_0000, fgr_reg};
      end else begin
        host_rdata_next = 8'h00;
      end
    end
    if (cpu_dbb_rd) begin
      cpu_rdata_next = ibuf_reg;
    end else if (cpu_sts_rd) begin
      cpu_rdata_next = status_byte;
    end
    en_flags_next = en_flags_reg || cpu_en_flags;
    tmr_pend_next = (tmr_pend_reg && !cpu_tmr_ack) || timer_ovf;
    kbd_host_interrupt_next = en_flags_next ? (kbd_irq_port_bit && obf_next) : kbd_irq_port_bit;
    aux_host_interrupt_next = en_flags_next ? (aux_irq_port_bit && !ibf_next) : aux_irq_port_bit;
    irq_req_next = {tmr_pend_next && cpu_tmr_irq_en, ibf_next && cpu_ibf_irq_en};
    ibf_irq_n_next = !(ibf_next && cpu_ibf_irq_en);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ibuf_reg <= 8'h00;
      obuf_reg <= 8'h00;
      obf_reg <= STS_RESET[STS_OBF];
      ibf_reg <= STS_RESET[STS_IBF];
      cd_reg <= STS_RESET[STS_CD];
      user_reg <= STS_RESET;
      host_rdata_reg <= 8'h00;
      cpu_rdata_reg <= 8'h00;
      fgr_reg <= FGR_RESET[1:0];
      en_flags_reg <= 1'b0;
      tmr_pend_reg <= 1'b0;
      kbd_host_interrupt_reg <= 1'b0;
      aux_host_interrupt_reg <= 1'b0;
      irq_req_reg <= 2'b00;
      ibf_irq_n_reg <= 1'b1;
    end else begin
      ibuf_reg <= ibuf_next;
      obuf_reg <= obuf_next;
      obf_reg <= obf_next;
      ibf_reg <= ibf_next;
      cd_reg <= cd_next;
      user_reg <= user_next;
      host_rdata_reg <= host_rdata_next;
      cpu_rdata_reg <= cpu_rdata_next;
      fgr_reg <= fgr_next;
      en_flags_reg <= en_flags_next;
      tmr_pend_reg <= tmr_pend_next;
      kbd_host_interrupt_reg <= kbd_host_interrupt_next;
      aux_host_interrupt_reg <= aux_host_interrupt_next;
      irq_req_reg <= irq_req_next;
      ibf_irq_n_reg <= ibf_irq_n_next;
    end
  end

  // Core reset stretch, clock-rate enable and power modes
  assign acc_sum = acc_reg + ACC_W'(CORE_CLK_MHZ);
  assign tick = (acc_sum >= ACC_W'(MCLK_MHZ));

  always_comb begin
    acc_next = tick ? acc_sum - ACC_W'(MCLK_MHZ) : acc_sum;
    rst_cnt_next = rst_cnt_reg;
    done_next = done_reg;
    if (!done_reg) begin
      if (rst_cnt_reg == 8'(RST_CYC - 1)) begin
        done_next = 1'b1;
      end else begin
        rst_cnt_next = rst_cnt_reg + 8'h01;
      end
    end
    pwr_next = pwr_reg;
    wake_call_next = 1'b0;
    wake_resume_next = 1'b0;
    case (pwr_reg)
      PWR_RUN: begin
        if (done_reg && cpu_stop) begin
          pwr_next = PWR_STOP;
        end else if (done_reg && cpu_halt) begin
          pwr_next = PWR_SLEEP;
        end
      end
      PWR_SLEEP, PWR_STOP: begin
        if (host_in_wr) begin
          pwr_next = PWR_RUN;
          wake_call_next = cpu_ibf_irq_en;
          wake_resume_next = !cpu_ibf_irq_en;
        end
      end
      default: pwr_next = PWR_RUN;
    endcase
    alu_en_next = tick && done_next && (pwr_next == PWR_RUN);
    per_en_next = tick && done_next && (pwr_next != PWR_STOP);
    line_low_next = done_next ? cpu_line_low : {LINE_COUNT{1'b1}};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= '0;
      rst_cnt_reg <= 8'h00;
      done_reg <= 1'b0;
      pwr_reg <= PWR_RUN;
      wake_call_reg <= 1'b0;
      wake_resume_reg <= 1'b0;
      alu_en_reg <= 1'b0;
      per_en_reg <= 1'b0;
      line_low_reg <= {LINE_COUNT{1'b1}};
      sense_reg <= '0;
    end else begin
      acc_reg <= acc_next;
      rst_cnt_reg <= rst_cnt_next;
      done_reg <= done_next;
      pwr_reg <= pwr_next;
      wake_call_reg <= wake_call_next;
      wake_resume_reg <= wake_resume_next;
      alu_en_reg <= alu_en_next;
      per_en_reg <= per_en_next;
      line_low_reg <= line_low_next;
      sense_reg <= ps2_line_in;
    end
  end

  // Open-drain lines only ever pull low
  for (genvar i = 0; i < LINE_COUNT; i++) begin : g_line
    assign ps2_line_out[i] = 1'b0;
    assign ps2_line_oe[i] = line_low_reg[i];
  end

  assign frif.arm = fgr_reg[FGR_RST];
  fast_reset_pulser u_pulser (
    .mclk(mclk),
    .rst_n(rst_n),
    .fr(frif.pulser)
  );

  // Fetch address forced to zero while the core is held in reset
  assign memif.fetch_addr = done_reg ? cpu_fetch_addr : '0;
  assign memif.load_en = rom_load_en;
  assign memif.load_addr = rom_load_addr;
  assign memif.load_data = rom_load_data;
  assign memif.ram_we = cpu_ram_we && done_reg;
  assign memif.ram_addr = cpu_ram_addr;
  assign memif.ram_wdata = cpu_ram_wdata;
  core_memory u_mem (
    .mclk(mclk),
    .mem(memif.mem)
  );

  assign host_rdata = host_rdata_reg;
  assign cpu_rdata = cpu_rdata_reg;
  assign kbd_host_interrupt = kbd_host_interrupt_reg;
  assign aux_host_interrupt = aux_host_interrupt_reg;
  assign alt_gate_line = fgr_reg[FGR_GATE];
  assign fast_cpu_reset_n = frif.reset_n;
  assign cpu_irq_req = irq_req_reg;
  assign cpu_input_full_irq_n = ibf_irq_n_reg;
  assign core_reset_n = done_reg;
  assign alu_clk_en = alu_en_reg;
  assign periph_clk_en = per_en_reg;
  assign osc_drive_en = (pwr_reg != PWR_STOP);
  assign wake_call = wake_call_reg;
  assign wake_resume = wake_resume_reg;
  assign ps2_line_sense = sense_reg;
  assign cpu_fetch_data = memif.fetch_data;
  assign cpu_ram_rdata = memif.ram_rdata;
endmodule

// ---- bench/kbc_host_mailbox_checker.sv ----
// Port-level assertions for the keyboard-controller mailbox
`timescale 1ns/1ps
module kbc_host_mailbox_checker #(
  parameter int RST_CYC = kbc_pkg::CORE_RST_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] kbd_reset_gate_cfg,
  input wire logic kbd_host_interrupt,
  input wire logic alt_gate_line,
  input wire logic fast_cpu_reset_n,
  input wire logic cpu_dbb_wr,
  input wire logic cpu_dbb_rd,
  input wire logic cpu_halt,
  input wire logic cpu_stop,
  input wire logic cpu_en_flags,
  input wire logic cpu_ibf_irq_en,
  input wire logic [1:0] cpu_irq_req,
  input wire logic cpu_input_full_irq_n,
  input wire logic kbd_irq_port_bit,
  input wire logic core_reset_n,
  input wire logic alu_clk_en,
  input wire logic periph_clk_en,
  input wire logic osc_drive_en,
  input wire logic wake_call,
  input wire logic wake_resume,
  input wire logic [kbc_pkg::LINE_COUNT-1:0] ps2_line_oe
);
  import kbc_pkg::*;
  logic flags_reg, asleep_reg, b0_reg;
  logic [7:0] rcnt_reg;
  logic [5:0] low_reg;
  wire mbox_wr = host_wr && (host_addr == ADDR_DATA || host_addr == ADDR_CMD);
  wire fast_wr = host_wr && host_addr == ADDR_FAST && kbd_reset_gate_cfg[CFG_FAST_EN_BIT];
  wire arm = fast_wr && host_wdata[FGR_RST] && !b0_reg;
  // Shadow state: flag mode, sleep, port bit 0 and low-time counters
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= 1'b0;
      asleep_reg <= 1'b0;
      b0_reg <= 1'b0;
      rcnt_reg <= 8'h00;
      low_reg <= 6'h00;
    end else begin
      flags_reg <= flags_reg | cpu_en_flags;
      asleep_reg <= (asleep_reg | cpu_halt | cpu_stop) & !mbox_wr;
      b0_reg <= fast_wr ? host_wdata[FGR_RST] : b0_reg;
      rcnt_reg <= core_reset_n ? 8'h00 : rcnt_reg + 8'h01;
      low_reg <= fast_cpu_reset_n ? 6'h00 : low_reg + 6'h01;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence fast_wait;
    fast_cpu_reset_n [*8] ##1 fast_cpu_reset_n [*6] ##1 !fast_cpu_reset_n;
  endsequence
  a_irq_raise: assert property (flags_reg && cpu_dbb_wr && kbd_irq_port_bit |=>
    kbd_host_interrupt) else $error("kbd irq not raised");
  a_irq_forced: assert property (flags_reg && !kbd_irq_port_bit |=>
    !kbd_host_interrupt) else $error("kbd irq not forced low");
  a_ibf_irq: assert property (mbox_wr && cpu_ibf_irq_en |=> !cpu_input_full_irq_n)
    else $error("input full irq missing");
  a_ibf_clear: assert property (cpu_dbb_rd && !mbox_wr |=>
    cpu_input_full_irq_n && !cpu_irq_req[0]) else $error("input full not cleared");
  a_fast_delay: assert property (arm |=> fast_wait)
    else $error("fast reset delay wrong");
  a_fast_width: assert property ($rose(fast_cpu_reset_n) |-> low_reg == FAST_PULSE_CYC)
    else $error("fast reset width wrong");
  a_fast_once: assert property ($fell(fast_cpu_reset_n) |-> $past(arm, 15))
    else $error("fast reset without arming");
  a_gate_level: assert property (fast_wr |=> alt_gate_line == $past(host_wdata[FGR_GATE]))
    else $error("gate line level wrong");
  a_core_hold: assert property ($rose(core_reset_n) |-> rcnt_reg >= RST_CYC)
    else $error("core reset too short");
  a_lines_low: assert property (!core_reset_n |-> ps2_line_oe == 4'hF)
    else $error("lines not held low");
  a_soft_sleep: assert property (cpu_halt && !cpu_stop |=> ##1 !alu_clk_en ##[0:4]
    periph_clk_en) else $error("soft sleep clocks wrong");
  a_hard_stop: assert property (cpu_stop |=> !osc_drive_en ##1
    !alu_clk_en && !periph_clk_en) else $error("hard stop clocks wrong");
  a_wake_kind: assert property (asleep_reg && mbox_wr |=> wake_call != wake_resume &&
    wake_call == $past(cpu_ibf_irq_en)) else $error("wake kind wrong");
endmodule
bind kbc_host_mailbox kbc_host_mailbox_checker #(.RST_CYC(RST_CYC)) chk_i (.*);

// ---- bench/host_io_model.sv ----
// Host processor model issuing byte I/O cycles to the mailbox
`timescale 1ns/1ps
module host_io_model (
  input wire logic mclk,
  output logic [7:0] host_addr,
  output logic host_wr,
  output logic host_rd,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata
);
  initial begin
    host_addr = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 8'h00;
  end
  task automatic io_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    host_addr <= a;
    host_wdata <= v;
    host_wr <= 1'b1;
    @(posedge mclk);
    host_wr <= 1'b0;
    // Released bus shows no stale value
    host_addr <= ~a;
    host_wdata <= ~v;
    @(negedge mclk);
  endtask
  task automatic io_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge mclk);
    host_rd <= 1'b0;
    host_addr <= ~a;
    @(negedge mclk);
    v = host_rdata;
  endtask
endmodule

// ---- bench/kbc_host_mailbox_tb.sv ----
// Self-checking bench for the keyboard-controller mailbox top
`timescale 1ns/1ps
module kbc_host_mailbox_tb;
  import kbc_pkg::*;
  logic mclk, rst_n, host_wr, host_rd, cpu_ibf_irq_en, cpu_tmr_irq_en, kbd_irq_port_bit;
  logic aux_irq_port_bit, kbd_host_interrupt, aux_host_interrupt, alt_gate_line;
  logic fast_cpu_reset_n, cpu_input_full_irq_n, core_reset_n, alu_clk_en, periph_clk_en;
  logic osc_drive_en, wake_call, wake_resume, rom_load_en, cpu_ram_we;
  logic [7:0] host_addr, host_wdata, host_rdata, kbd_reset_gate_cfg, cpu_wdata, cpu_rdata;
  logic [7:0] cpu_fetch_data, rom_load_data, cpu_ram_wdata, cpu_ram_rdata, r, d, ub, a;
  logic [RAM_AW-1:0] cpu_ram_addr;
  logic [ROM_AW-1:0] cpu_fetch_addr, rom_load_addr, ma;
  logic [LINE_COUNT-1:0] cpu_line_low, ps2_line_in, ps2_line_out, ps2_line_oe, ps2_line_sense;
  logic [1:0] cpu_irq_req;
  logic [8:0] cs;
  logic [1:0] tab[4] = '{2'b11, 2'b01, 2'b00, 2'b01};
  int nf[4] = '{1, 1, 1, 2};
  int seed, n_errors, n_compared, cyc, n_fall, n_alu, n_per, n_call, n_res, k, j;
  // Core strobes: 0 dbb wr, 1 dbb rd, 2 sts wr, 3 sts rd, 4 halt, 5 stop, 6 flags, 7 ovf, 8 ack
  wire cpu_dbb_wr = cs[0];
  wire cpu_dbb_rd = cs[1];
  wire cpu_sts_wr = cs[2];
  wire cpu_sts_rd = cs[3];
  wire cpu_halt = cs[4];
  wire cpu_stop = cs[5];
  wire cpu_en_flags = cs[6];
  wire timer_ovf = cs[7];
  wire cpu_tmr_ack = cs[8];
  // Open-drain lines with pull-ups
  assign ps2_line_in = ~ps2_line_oe;
  kbc_host_mailbox kbc_host_mailbox_i (.*);
  host_io_model host_io_model_i (.*);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    n_alu += alu_clk_en;
    n_per += periph_clk_en;
    n_call += wake_call;
    n_res += wake_resume;
    if (cyc == 5000) begin
      n_errors++;
      give_verdict();
    end
  end
  always @(negedge fast_cpu_reset_n) n_fall++;
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [7:0] sts(input logic [7:0] u, input logic cd, input_full_flag, output_full_flag);
    return (u & STS_USER_MASK) | {4'h0, cd, 1'b0, input_full_flag, output_full_flag};
  endfunction
  task automatic strb(input int i, input logic [7:0] v);
    @(posedge mclk);
    cs[i] <= 1'b1;
    cpu_wdata <= v;
    @(posedge mclk);
    cs <= '0;
    @(negedge mclk);
  endtask
  task automatic core_up();
    for (k = 0; k < 100 && core_reset_n !== 1'b1; k++) @(negedge mclk);
    chk("core_up", core_reset_n, 1'b1);
  endtask
  initial begin
    seed = 32'h9de0_e276;
    {rst_n, cs, cpu_wdata, kbd_reset_gate_cfg, cpu_line_low, ub} = '0;
    {cpu_ibf_irq_en, cpu_tmr_irq_en, kbd_irq_port_bit, aux_irq_port_bit} = 4'hF;
    {cpu_fetch_addr, rom_load_en, rom_load_addr, rom_load_data} = '0;
    {cpu_ram_we, cpu_ram_addr, cpu_ram_wdata} = '0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk("oe_rst", ps2_line_oe, 4'hF);
    host_io_model_i.io_rd(ADDR_CMD, r);
    chk("sts_rst", r, STS_RESET);
    core_up();
    strb(6, 8'h00);
    for (int i = 0; i < 12; i++) begin
      d = 8'($random(seed));
      a = d[0] ? ADDR_CMD : ADDR_DATA;
      host_io_model_i.io_wr(a, d);
      chk("irq_in", {cpu_irq_req[0], cpu_input_full_irq_n, aux_host_interrupt}, 3'b100);
      host_io_model_i.io_rd(ADDR_CMD, r);
      chk("sts_in", r, sts(ub, a[ADDR_CMD_BIT], 1'b1, 1'b0));
      strb(1, 8'h00);
      chk("cpu_rd", {cpu_rdata, 6'h00, aux_host_interrupt, cpu_input_full_irq_n},
        {d, 8'h03});
      r = 8'($random(seed));
      strb(0, r);
      chk("kbd_host_interrupt_set", kbd_host_interrupt, 1'b1);
      host_io_model_i.io_rd(ADDR_CMD, d);
      chk("sts_out", d, sts(ub, a[ADDR_CMD_BIT], 1'b0, 1'b1));
      host_io_model_i.io_rd(ADDR_DATA, d);
      chk("obuf", {d, 7'h00, kbd_host_interrupt}, {r, 8'h00});
      ub = 8'($random(seed));
      strb(2, ub);
      strb(3, 8'h00);
      chk("sts_cpu", cpu_rdata, sts(ub, a[ADDR_CMD_BIT], 1'b0, 1'b0));
    end
    @(posedge mclk) kbd_irq_port_bit <= 1'b0;
    strb(0, 8'h5a);
    chk("kbd_host_interrupt_low", kbd_host_interrupt, 1'b0);
    host_io_model_i.io_rd(ADDR_DATA, d);
    @(posedge mclk) kbd_irq_port_bit <= 1'b1;
    strb(7, 8'h00);
    chk("tmr_irq", cpu_irq_req[1], 1'b1);
    strb(8, 8'h00);
    chk("tmr_ack", cpu_irq_req[1], 1'b0);
    host_io_model_i.io_wr(ADDR_FAST, 8'h03);
    host_io_model_i.io_rd(ADDR_FAST, d);
    chk("fast_off", {d, 7'h00, alt_gate_line}, 16'h0000);
    d = 8'($random(seed));
    @(posedge mclk) kbd_reset_gate_cfg <= d | 8'h04;
    host_io_model_i.io_rd(ADDR_FAST, d);
    chk("fast_dflt", d, FGR_RESET);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      d[1:0] = tab[i];
      host_io_model_i.io_wr(ADDR_FAST, d);
      chk("gate", alt_gate_line, d[FGR_GATE]);
      repeat (45) @(negedge mclk);
      host_io_model_i.io_rd(ADDR_FAST, r);
      chk("fast_rd", r, FGR_FIXED | {6'h00, d[1:0]});
      chk("falls", 16'(n_fall), 16'(nf[i]));
    end
    strb(4, 8'h00);
    @(negedge mclk);
    k = n_alu;
    j = n_per;
    repeat (10) @(negedge mclk);
    chk("sleep", {16'(n_alu - k), 16'(n_per - j) >= 4}, 17'h1);
    k = n_call;
    host_io_model_i.io_wr(ADDR_DATA, 8'ha5);
    @(negedge mclk);
    chk("wake_call", 16'(n_call - k), 16'h1);
    strb(1, 8'h00);
    @(posedge mclk) cpu_ibf_irq_en <= 1'b0;
    strb(5, 8'h00);
    @(negedge mclk);
    j = n_per;
    repeat (10) @(negedge mclk);
    chk("frozen", {osc_drive_en, 16'(n_per - j)}, 17'h0);
    k = n_res;
    host_io_model_i.io_wr(ADDR_CMD, 8'h3c);
    @(negedge mclk);
    chk("wake_res", {osc_drive_en, 16'(n_res - k)}, 17'h10001);
    strb(4, 8'h00);
    @(posedge mclk) rst_n <= 1'b0;
    @(posedge mclk) rst_n <= 1'b1;
    @(negedge mclk);
    chk("core_rst", core_reset_n, 1'b0);
    host_io_model_i.io_rd(ADDR_CMD, d);
    host_io_model_i.io_rd(ADDR_FAST, r);
    chk("regs_rst", {d, r, alt_gate_line}, {STS_RESET, FGR_RESET, 1'b0});
    core_up();
    k = n_alu;
    repeat (10) @(negedge mclk);
    chk("alu_run", 16'(n_alu - k) >= 4, 1'b1);
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      ma = (i == 0) ? '1 : (i == 1) ? '0 : {d[2:0], d};
      @(posedge mclk);
      cpu_line_low <= d[3:0];
      {rom_load_en, rom_load_addr, rom_load_data} <= {1'b1, ma, d};
      {cpu_ram_we, cpu_ram_addr, cpu_ram_wdata} <= {1'b1, ma[7:0], ~d};
      @(posedge mclk);
      {rom_load_en, cpu_ram_we, cpu_fetch_addr} <= {2'b00, ma};
      @(posedge mclk);
      @(negedge mclk);
      chk("lines", {ps2_line_oe, ps2_line_sense, ps2_line_out}, {d[3:0], ~d[3:0], 4'h0});
      chk("mem", {cpu_fetch_data, cpu_ram_rdata}, {d, ~d});
    end
    give_verdict();
  end
endmodule
